// File: adc_output_config_registers.sv
// register bank for converter clock gain, test patterns, gains and serial output framing
//
// Implementation choice: register access over Avalon-MM.
module adc_output_config_registers #(
   parameter int NUM_CH = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_link,
   input wire logic i_link_rst,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [6:0] i_pin_ctl,
   input wire logic [NUM_CH*adc_cfg_pkg::SAMPLE_W-1:0] i_link_sample,
   output logic [NUM_CH-1:0] o_lane_a,
   output logic [NUM_CH-1:0] o_lane_b,
   output logic o_frame,
   output logic o_sdr,
   output logic o_capture_rising,
   output logic [2:0] o_clk_gain_step,
   output logic [2:0] o_fine_gain_db,
   output logic o_coarse_gain_en,
   output logic o_cfg_busy
);
   logic [10:0] test_pattern_and_format_reg;
   logic [10:0] clock_buffer_gain_reg;
   logic [10:0] custom_pattern_low_reg;
   logic [10:0] fine_gain_custom_high_reg;
   logic [10:0] output_interface_control_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [6:0] pin_s;
   logic ack_s;
   logic busy_reg;
   logic req_tog_reg;
   adc_cfg_pkg::link_cfg_s hold_reg;
   logic [2:0] clk_step_reg;
   logic [2:0] fine_reg;
   logic coarse_reg;

   cfg_link_if link_bus ();

   // bus decode
   logic rdata_pending_reg;
   wire req = i_avs_read | i_avs_write;
   wire take = req & wait_reg & ~rdata_pending_reg;
   wire [5:0] idx = i_avs_address[7:2];
   wire hit_test = (idx == adc_cfg_pkg::IDX_TEST_PATTERN);
   wire hit_gain = (idx == adc_cfg_pkg::IDX_CLOCK_GAIN);
   wire hit_clo = (idx == adc_cfg_pkg::IDX_CUSTOM_LOW);
   wire hit_chi = (idx == adc_cfg_pkg::IDX_FINE_CUSTOM);
   wire hit_out = (idx == adc_cfg_pkg::IDX_OUTPUT_CTL);
   wire do_wr = take & i_avs_write;
   wire [10:0] be_mask = {{3{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   wire [10:0] wdata = i_avs_writedata[10:0];

   // unmapped addresses read zero and ignore writes
   wire [10:0] rd_mux =
      hit_test ? test_pattern_and_format_reg :
      hit_gain ? clock_buffer_gain_reg :
      hit_clo ? custom_pattern_low_reg :
      hit_chi ? fine_gain_custom_high_reg :
      hit_out ? output_interface_control_reg : 11'h000;

   // several fields of one register change in a single write
   function automatic logic [10:0] merge(input logic [10:0] old, input logic [10:0] nw,
                                         input logic [10:0] be, input logic [10:0] msk);
      merge = ((old & ~be) | (nw & be)) & msk;
   endfunction : merge

   // bus handshake: request taken when waitrequest high, answered one cycle later
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wait_reg <= 1'b1;
         rdata_pending_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= ~take;
         rdata_pending_reg <= take;
         if (take && i_avs_read) begin
            rdata_reg <= {21'h000000, rd_mux};
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         test_pattern_and_format_reg <= adc_cfg_pkg::RST_ALL;
         clock_buffer_gain_reg <= adc_cfg_pkg::RST_ALL;
         custom_pattern_low_reg <= adc_cfg_pkg::RST_ALL;
         fine_gain_custom_high_reg <= adc_cfg_pkg::RST_ALL;
         output_interface_control_reg <= adc_cfg_pkg::RST_ALL;
      end else if (do_wr) begin
         if (hit_test) begin
            test_pattern_and_format_reg <= merge(test_pattern_and_format_reg, wdata, be_mask,
               adc_cfg_pkg::MASK_TEST_PATTERN);
         end
         if (hit_gain) begin
            clock_buffer_gain_reg <= merge(clock_buffer_gain_reg, wdata, be_mask,
               adc_cfg_pkg::MASK_CLOCK_GAIN);
         end
         if (hit_clo) begin
            custom_pattern_low_reg <= merge(custom_pattern_low_reg, wdata, be_mask,
               adc_cfg_pkg::MASK_CUSTOM_LOW);
         end
         if (hit_chi) begin
            fine_gain_custom_high_reg <= merge(fine_gain_custom_high_reg, wdata, be_mask,
               adc_cfg_pkg::MASK_FINE_CUSTOM);
         end
         if (hit_out) begin
            output_interface_control_reg <= merge(output_interface_control_reg, wdata, be_mask,
               adc_cfg_pkg::MASK_OUTPUT_CTL);
         end
      end
   end

   // parallel control pins come from outside and are synchronised
   sync_2ff #(.W(7)) u_pin_sync (
      .i_clk(i_clk_sys),
      .i_rst(i_sys_rst),
      .i_d(i_pin_ctl),
      .o_q(pin_s)
   );

   // pin order: 0 two lanes, 1 sdr, 2 16x, 3 rising edge, 4 coarse gain, 5 lsb first, 6 bit-wise
   wire ovr = output_interface_control_reg[adc_cfg_pkg::POS_OVERRIDE];
   wire [10:0] ocr = output_interface_control_reg;
   wire eff_two_lane = ovr ? ocr[adc_cfg_pkg::POS_TWO_LANE] : pin_s[0];
   wire eff_sdr = ovr ? ocr[adc_cfg_pkg::POS_SDR] : pin_s[1];
   wire eff_ser16 = ovr ? ocr[adc_cfg_pkg::POS_SER16] : pin_s[2];
   wire eff_rising = ovr ? ocr[adc_cfg_pkg::POS_RISING] : pin_s[3];
   wire eff_coarse = ovr ? ocr[adc_cfg_pkg::POS_COARSE] : pin_s[4];
   wire eff_lsb = ovr ? ocr[adc_cfg_pkg::POS_LSB_FIRST] : pin_s[5];
   wire eff_bitwise = ovr ? ocr[adc_cfg_pkg::POS_BITWISE] : pin_s[6];

   adc_cfg_pkg::link_cfg_s eff_cfg;
   always_comb begin
      eff_cfg.pattern = test_pattern_and_format_reg[adc_cfg_pkg::POS_PATTERN +: 3];
      eff_cfg.custom = {fine_gain_custom_high_reg[2:0], custom_pattern_low_reg};
      eff_cfg.straight_binary = test_pattern_and_format_reg[adc_cfg_pkg::POS_CODING];
      eff_cfg.two_lane = eff_two_lane;
      eff_cfg.sdr = eff_sdr;
      eff_cfg.ser16 = eff_ser16;
      eff_cfg.rising = eff_rising;
      eff_cfg.lsb_first = eff_lsb;
      eff_cfg.bitwise = eff_bitwise;
   end

   // configuration word crossing by toggle handshake; hold_reg is stable while busy
   sync_2ff #(.W(1)) u_ack_sync (
      .i_clk(i_clk_sys),
      .i_rst(i_sys_rst),
      .i_d(link_bus.ack_tog),
      .o_q(ack_s)
   );

   wire launch = ~busy_reg & (eff_cfg != hold_reg);

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         hold_reg <= '0;
         req_tog_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (launch) begin
         hold_reg <= eff_cfg;
         req_tog_reg <= ~req_tog_reg;
         busy_reg <= 1'b1;
      end else if (busy_reg && ack_s == req_tog_reg) begin
         busy_reg <= 1'b0;
      end
   end

   assign link_bus.hold = hold_reg;
   assign link_bus.req_tog = req_tog_reg;

   // clock buffer gain step; unlisted codes read as the reset step
   wire [4:0] clk_code = clock_buffer_gain_reg[adc_cfg_pkg::POS_CLK_GAIN +: 5];
   logic [2:0] clk_step_next;
   always_comb begin
      case (clk_code)
         adc_cfg_pkg::CLK_GAIN_0: clk_step_next = 3'h0;
         adc_cfg_pkg::CLK_GAIN_1: clk_step_next = 3'h1;
         adc_cfg_pkg::CLK_GAIN_2: clk_step_next = 3'h2;
         adc_cfg_pkg::CLK_GAIN_3: clk_step_next = 3'h3;
         adc_cfg_pkg::CLK_GAIN_4: clk_step_next = 3'h4;
         adc_cfg_pkg::CLK_GAIN_5: clk_step_next = 3'h5;
         default: clk_step_next = 3'h1;
      endcase
   end

   wire [2:0] fine_code = fine_gain_custom_high_reg[adc_cfg_pkg::POS_FINE_GAIN +: 3];
   wire [2:0] fine_next = (fine_code > adc_cfg_pkg::FINE_GAIN_MAX) ?
      adc_cfg_pkg::FINE_GAIN_MAX : fine_code;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         clk_step_reg <= 3'h1;
         fine_reg <= 3'h0;
         coarse_reg <= 1'b0;
      end else begin
         clk_step_reg <= clk_step_next;
         fine_reg <= fine_next;
         coarse_reg <= eff_coarse;
      end
   end

   lane_serializer #(.NUM_CH(NUM_CH)) u_ser (
      .i_clk_link(i_clk_link),
      .i_link_rst(i_link_rst),
      .cfg(link_bus.link),
      .i_link_sample(i_link_sample),
      .o_lane_a(o_lane_a),
      .o_lane_b(o_lane_b),
      .o_frame(o_frame),
      .o_sdr(o_sdr),
      .o_capture_rising(o_capture_rising)
   );

   assign o_avs_readdata = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_clk_gain_step = clk_step_reg;
   assign o_fine_gain_db = fine_reg;
   assign o_coarse_gain_en = coarse_reg;
   assign o_cfg_busy = busy_reg;
endmodule : adc_output_config_registers

// File: adc_cfg_pkg.sv
// constants, field layout and config bundle of the converter output configuration block
package adc_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_TEST_PATTERN = 6'h00;
   localparam logic [5:0] IDX_CLOCK_GAIN = 6'h04;
   localparam logic [5:0] IDX_CUSTOM_LOW = 6'h0B;
   localparam logic [5:0] IDX_FINE_CUSTOM = 6'h0C;
   localparam logic [5:0] IDX_OUTPUT_CTL = 6'h0D;
   localparam int REG_W = 11;
   // writable bits of each register, all others read as zero
   localparam logic [10:0] MASK_TEST_PATTERN = 11'h2E0;
   localparam logic [10:0] MASK_CLOCK_GAIN = 11'h07C;
   localparam logic [10:0] MASK_CUSTOM_LOW = 11'h7FF;
   localparam logic [10:0] MASK_FINE_CUSTOM = 11'h707;
   localparam logic [10:0] MASK_OUTPUT_CTL = 11'h4F7;
   localparam logic [10:0] RST_ALL = 11'h000;
   // field positions
   localparam int POS_PATTERN = 5;
   localparam int POS_CODING = 9;
   localparam int POS_CLK_GAIN = 2;
   localparam int POS_FINE_GAIN = 8;
   localparam int POS_TWO_LANE = 0;
   localparam int POS_SDR = 1;
   localparam int POS_SER16 = 2;
   localparam int POS_RISING = 4;
   localparam int POS_COARSE = 5;
   localparam int POS_LSB_FIRST = 6;
   localparam int POS_BITWISE = 7;
   localparam int POS_OVERRIDE = 10;
   // output source selection
   localparam logic [2:0] PAT_NORMAL = 3'h0;
   localparam logic [2:0] PAT_ZEROS = 3'h1;
   localparam logic [2:0] PAT_ONES = 3'h2;
   localparam logic [2:0] PAT_TOGGLE = 3'h3;
   localparam logic [2:0] PAT_CUSTOM = 3'h5;
   localparam logic [2:0] PAT_ALIGN = 3'h6;
   localparam logic [2:0] PAT_SYNC = 3'h7;
   localparam logic [13:0] WORD_ALIGN = 14'h2AAA;
   localparam logic [13:0] WORD_TOGGLE_ALT = 14'h1555;
   localparam logic [13:0] WORD_SYNC = 14'h3F80;
   // clock buffer gain codes, step 0 lowest to step 5 highest
   localparam logic [4:0] CLK_GAIN_0 = 5'h18;
   localparam logic [4:0] CLK_GAIN_1 = 5'h00;
   localparam logic [4:0] CLK_GAIN_2 = 5'h0C;
   localparam logic [4:0] CLK_GAIN_3 = 5'h0A;
   localparam logic [4:0] CLK_GAIN_4 = 5'h09;
   localparam logic [4:0] CLK_GAIN_5 = 5'h08;
   localparam logic [2:0] FINE_GAIN_MAX = 3'h5;
   localparam int SAMPLE_W = 14;
   localparam int WORD_W = 16;

   typedef struct packed {
      logic [2:0] pattern;
      logic [13:0] custom;
      logic straight_binary;
      logic two_lane;
      logic sdr;
      logic ser16;
      logic rising;
      logic lsb_first;
      logic bitwise;
   } link_cfg_s;
endpackage : adc_cfg_pkg

// File: cfg_link_if.sv
// configuration word and handshake toggles between system and link domains
interface cfg_link_if;
   adc_cfg_pkg::link_cfg_s hold;
   logic req_tog;
   logic ack_tog;
   modport sys (output hold, output req_tog, input ack_tog);
   modport link (input hold, input req_tog, output ack_tog);
endinterface : cfg_link_if

// File: sync_2ff.sv
// two flip-flop synchroniser for levels
module sync_2ff #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= i_d;
         q_reg <= meta_reg;
      end
   end

   assign o_q = q_reg;
endmodule : sync_2ff

// File: lane_serializer.sv
// link-domain serializer: per-channel lanes, pattern insertion, framing
module lane_serializer #(
   parameter int NUM_CH = 4
) (
   input wire logic i_clk_link,
   input wire logic i_link_rst,
   cfg_link_if.link cfg,
   input wire logic [NUM_CH*adc_cfg_pkg::SAMPLE_W-1:0] i_link_sample,
   output logic [NUM_CH-1:0] o_lane_a,
   output logic [NUM_CH-1:0] o_lane_b,
   output logic o_frame,
   output logic o_sdr,
   output logic o_capture_rising
);
   localparam int SW = adc_cfg_pkg::SAMPLE_W;
   localparam int WW = adc_cfg_pkg::WORD_W;

   adc_cfg_pkg::link_cfg_s cur_reg;
   logic req_s;
   logic ack_reg;
   logic [3:0] cnt_reg;
   logic tog_reg;
   logic frame_reg;
   logic sdr_reg;
   logic rising_reg;
   logic [NUM_CH-1:0][WW-1:0] sa_reg;
   logic [NUM_CH-1:0][WW-1:0] sb_reg;

   wire [4:0] bits_per_word = cur_reg.ser16 ? 5'h10 : 5'h0E;
   wire [4:0] cycles = cur_reg.two_lane ? (bits_per_word >> 1) : bits_per_word;
   wire last = ({1'b0, cnt_reg} == cycles - 5'h01);
   wire [3:0] half = bits_per_word[4:1];

   sync_2ff #(.W(1)) u_req_sync (
      .i_clk(i_clk_link),
      .i_rst(i_link_rst),
      .i_d(cfg.req_tog),
      .o_q(req_s)
   );

   // new settings are applied only at a frame boundary
   always_ff @(posedge i_clk_link) begin
      if (i_link_rst) begin
         cur_reg <= '0;
         ack_reg <= 1'b0;
      end else if (req_s != ack_reg && last) begin
         cur_reg <= cfg.hold;
         ack_reg <= req_s;
      end
   end
   assign cfg.ack_tog = ack_reg;

   always_ff @(posedge i_clk_link) begin
      if (i_link_rst) begin
         cnt_reg <= 4'h0;
         tog_reg <= 1'b0;
         frame_reg <= 1'b0;
         sdr_reg <= 1'b0;
         rising_reg <= 1'b0;
      end else begin
         cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
         tog_reg <= last ? ~tog_reg : tog_reg;
         frame_reg <= last;
         sdr_reg <= cur_reg.two_lane & cur_reg.sdr;
         rising_reg <= cur_reg.two_lane & cur_reg.sdr & cur_reg.rising;
      end
   end

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [SW-1:0] raw;
      logic [SW-1:0] src;
      logic [WW-1:0] fwd;
      logic [WW-1:0] rev;
      logic [WW-1:0] word;
      logic [WW-1:0] even;
      logic [WW-1:0] odd;
      assign raw = i_link_sample[ch*SW +: SW];
      always_comb begin
         case (cur_reg.pattern)
            adc_cfg_pkg::PAT_NORMAL: src = {raw[SW-1] ^ cur_reg.straight_binary, raw[SW-2:0]};
            adc_cfg_pkg::PAT_ZEROS: src = '0;
            adc_cfg_pkg::PAT_ONES: src = '1;
            adc_cfg_pkg::PAT_TOGGLE: src = tog_reg ? adc_cfg_pkg::WORD_TOGGLE_ALT : adc_cfg_pkg::WORD_ALIGN;
            adc_cfg_pkg::PAT_CUSTOM: src = cur_reg.custom;
            adc_cfg_pkg::PAT_ALIGN: src = adc_cfg_pkg::WORD_ALIGN;
            adc_cfg_pkg::PAT_SYNC: src = adc_cfg_pkg::WORD_SYNC;
            default: src = '0;
         endcase
      end
      assign fwd = {src, 2'b00};
      for (genvar k = 0; k < WW; k++) begin : g_rev
         assign rev[k] = fwd[WW-1-k];
      end
      // reversed word is left-aligned over the active serialization length
      assign word = !cur_reg.lsb_first ? fwd : (cur_reg.ser16 ? rev : rev << 2);
      for (genvar k = 0; k < WW/2; k++) begin : g_split
         assign even[WW-1-k] = word[WW-1-2*k];
         assign odd[WW-1-k] = word[WW-2-2*k];
         assign even[k] = 1'b0;
         assign odd[k] = 1'b0;
      end
      always_ff @(posedge i_clk_link) begin
         if (i_link_rst) begin
            sa_reg[ch] <= '0;
            sb_reg[ch] <= '0;
         end else if (last) begin
            if (!cur_reg.two_lane) begin
               sa_reg[ch] <= word;
               sb_reg[ch] <= '0;
            end else if (cur_reg.bitwise) begin
               sa_reg[ch] <= even;
               sb_reg[ch] <= odd;
            end else begin
               sa_reg[ch] <= word;
               sb_reg[ch] <= word << half;
            end
         end else begin
            sa_reg[ch] <= sa_reg[ch] << 1;
            sb_reg[ch] <= sb_reg[ch] << 1;
         end
      end
      assign o_lane_a[ch] = sa_reg[ch][WW-1];
      assign o_lane_b[ch] = sb_reg[ch][WW-1];
   end

   assign o_frame = frame_reg;
   assign o_sdr = sdr_reg;
   assign o_capture_rising = rising_reg;
endmodule : lane_serializer

// File: adc_cfg_checker.sv
// assertion checker for the register bank bus and link status outputs
module adc_cfg_checker (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_link,
   input wire logic i_link_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_frame,
   input wire logic o_sdr,
   input wire logic o_capture_rising,
   input wire logic [2:0] o_clk_gain_step,
   input wire logic [2:0] o_fine_gain_db,
   input wire logic o_cfg_busy
);
   sequence s_taken;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_answer;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   a_bus_answer: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_taken |=> s_answer) else $error("bus answer not one cycle after request");
   a_no_spurious: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer without request");
   a_upper_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !o_avs_waitrequest |-> o_avs_readdata[31:11] == 21'h0) else $error("upper bits set");
   a_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $changed(o_avs_readdata) |-> !o_avs_waitrequest) else $error("read data moved");
   a_gain_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_clk_gain_step <= 3'h5) else $error("gain step out of range");
   a_fine_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_fine_gain_db <= 3'h5) else $error("fine gain out of range");
   a_reset_outs: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $past(i_sys_rst) |-> o_avs_waitrequest && o_clk_gain_step == 3'h1)
      else $error("wrong value after reset");
   a_busy_bound: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(o_cfg_busy) |-> ##[1:200] !o_cfg_busy) else $error("crossing never ends");
   a_frame_gap: assert property (@(posedge i_clk_link) disable iff (i_link_rst)
      o_frame |=> !o_frame [*6]) else $error("frames too close");
   a_edge_sdr: assert property (@(posedge i_clk_link) disable iff (i_link_rst)
      o_capture_rising |-> o_sdr) else $error("capture edge without sdr");
endmodule : adc_cfg_checker

bind adc_output_config_registers adc_cfg_checker u_chk (.i_clk_sys(i_clk_sys),
   .i_sys_rst(i_sys_rst), .i_clk_link(i_clk_link), .i_link_rst(i_link_rst),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_frame(o_frame), .o_sdr(o_sdr),
   .o_capture_rising(o_capture_rising), .o_clk_gain_step(o_clk_gain_step),
   .o_fine_gain_db(o_fine_gain_db), .o_cfg_busy(o_cfg_busy));

// File: lane_receiver.sv
// receiver model: rebuilds channel 0 words from the serial lanes
module lane_receiver (
   input wire logic i_clk_link,
   input wire logic i_frame,
   input wire logic i_lane_a,
   input wire logic i_lane_b,
   input wire logic i_two_lane,
   input wire logic i_ser16,
   input wire logic i_lsb_first,
   input wire logic i_bitwise,
   output logic [13:0] o_word,
   output int o_words
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] w = 16'h0000;
   int c = 0;
   initial begin
      o_word = 14'h0000;
      o_words = 0;
   end
   function automatic void put(input int p, input logic b);
      int n;
      n = i_ser16 ? 16 : 14;
      if (p < n) begin
         w[i_lsb_first ? p : n - 1 - p] = b;
      end
   endfunction : put
   always @(posedge i_clk_link) begin
      if (i_frame) begin
         o_word <= i_ser16 ? w[15:2] : w[13:0];
         o_words <= o_words + 1;
         c = 0;
      end
      if (!i_two_lane) begin
         put(c, i_lane_a);
      end else if (i_bitwise) begin
         put(2 * c, i_lane_a);
         put(2 * c + 1, i_lane_b);
      end else begin
         put(c, i_lane_a);
         put(c + (i_ser16 ? 8 : 7), i_lane_b);
      end
      c = c + 1;
   end
endmodule : lane_receiver

// File: adc_output_config_registers_tb.sv
// self-checking bench for the register bank and its serial link
module adc_output_config_registers_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NCH = 4;
   logic i_clk_sys, i_sys_rst, i_clk_link, i_link_rst, rd, wr, waitreq;
   logic frame, sdr, rise, coarse, busy, two, s16, lsb, bw;
   logic [7:0] adr;
   logic [31:0] wdat, rdata, rdat;
   logic [6:0] pins;
   logic [NCH*14-1:0] samp;
   logic [NCH-1:0] la, lb;
   logic [2:0] gstep, fdb;
   logic [13:0] rx_word;
   logic [13:0] cust = 14'h2D3B;
   int rx_words, err_count, tests_run, cyc;
   logic [7:0] addr_tab [5] = '{8'h00, 8'h10, 8'h2C, 8'h30, 8'h34};
   logic [10:0] mask_tab [5] = '{11'h2E0, 11'h07C, 11'h7FF, 11'h707, 11'h4F7};
   logic [4:0] gcode [6] = '{5'h18, 5'h00, 5'h0C, 5'h0A, 5'h09, 5'h08};
   logic [10:0] ctl_tab [5] = '{11'h400, 11'h444, 11'h401, 11'h497, 11'h4C3};
   logic [2:0] pat_tab [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
   logic [13:0] pat_exp [5] = '{14'h0000, 14'h3FFF, 14'h0000, 14'h2AAA, 14'h3F80};
   adc_output_config_registers #(.NUM_CH(NCH)) dut (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_link(i_clk_link),
      .i_link_rst(i_link_rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_pin_ctl(pins), .i_link_sample(samp), .o_lane_a(la),
      .o_lane_b(lb), .o_frame(frame), .o_sdr(sdr), .o_capture_rising(rise),
      .o_clk_gain_step(gstep), .o_fine_gain_db(fdb), .o_coarse_gain_en(coarse),
      .o_cfg_busy(busy));
   lane_receiver rx (.i_clk_link(i_clk_link), .i_frame(frame), .i_lane_a(la[0]),
      .i_lane_b(lb[0]), .i_two_lane(two), .i_ser16(s16), .i_lsb_first(lsb),
      .i_bitwise(bw), .o_word(rx_word), .o_words(rx_words));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      i_clk_link = 1'b0;
      #1.7;
      forever #3 i_clk_link = ~i_clk_link;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [10:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      adr <= a;
      wdat <= {21'h0, d};
      wr <= w;
      rd <= !w;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      rdat = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      chk("waitrequest", 32'h0, {31'h0, waitreq});
   endtask : bus
   task automatic rchk(input string nm, input logic [7:0] a, input logic [10:0] e);
      bus(1'b0, a, 11'h0);
      chk(nm, {21'h0, e}, rdat);
   endtask : rchk
   task automatic mode(input logic [10:0] c);
      bus(1'b1, 8'h34, c);
      two = c[0];
      s16 = c[2];
      lsb = c[6];
      bw = c[7];
   endtask : mode
   task automatic settle();
      int n, b;
      n = 0;
      repeat (2) @(posedge i_clk_sys);
      while (busy !== 1'b0 && n < 500) begin
         @(posedge i_clk_sys);
         n++;
      end
      b = rx_words;
      while (rx_words < b + 3 && n < 1000) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk("settle", 32'h0, 32'(n >= 1000));
      chk("lanes a", 32'({NCH{la[0]}}), 32'(la));
      chk("lanes b", 32'({NCH{lb[0]}}), 32'(lb));
      chk("lane b idle", 32'h0, 32'(two ? 4'h0 : lb));
   endtask : settle
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         $display("MISMATCH timeout expected done seen running");
         summarize();
      end
   end
   initial begin
      {i_sys_rst, i_link_rst} = 2'b11;
      {rd, wr, two, s16, lsb, bw} = 6'h0;
      adr = 8'h00;
      wdat = 32'h0;
      pins = 7'h00;
      samp = '0;
      {err_count, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
      repeat (5) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      i_link_rst <= 1'b0;
      @(posedge i_clk_sys);
      chk("gain after reset", 32'h1, {29'h0, gstep});
      for (int i = 0; i < 5; i++) begin
         rchk("reset value", addr_tab[i], 11'h000);
         bus(1'b1, addr_tab[i], mask_tab[i]);
         rchk("readback", addr_tab[i], mask_tab[i]);
      end
      bus(1'b1, 8'h08, 11'h7FF);
      rchk("unmapped", 8'h08, 11'h000);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 8'h10, {4'h0, gcode[i], 2'h0});
         repeat (4) @(posedge i_clk_sys);
         chk("gain step", i, {29'h0, gstep});
      end
      bus(1'b1, 8'h10, 11'h07C);
      repeat (4) @(posedge i_clk_sys);
      chk("gain unlisted", 32'h1, {29'h0, gstep});
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'h30, {i[2:0], 8'h00});
         repeat (4) @(posedge i_clk_sys);
         chk("fine gain", (i > 5) ? 5 : i, {29'h0, fdb});
      end
      pins <= 7'h10;
      foreach (ctl_tab[i]) begin
         bus(1'b1, 8'h34, (i == 0) ? 11'h000 : (i == 1) ? 11'h400 : 11'h420);
         repeat (6) @(posedge i_clk_sys);
         chk("coarse gain", (i == 1) ? 32'h0 : 32'h1, {31'h0, coarse});
         if (i == 2) break;
      end
      bus(1'b1, 8'h2C, cust[10:0]);
      bus(1'b1, 8'h30, {8'h00, cust[13:11]});
      bus(1'b1, 8'h00, 11'h0A0);
      for (int i = 0; i < 5; i++) begin
         mode(ctl_tab[i]);
         settle();
         chk("custom word", cust, rx_word);
         chk("sdr", ctl_tab[i][1] & ctl_tab[i][0], sdr);
         chk("edge", ctl_tab[i][1] & ctl_tab[i][0] & ctl_tab[i][4], rise);
      end
      pins <= 7'h24;
      mode(11'h003);
      {two, s16, lsb} = 3'b011;
      settle();
      chk("pin framing", cust, rx_word);
      chk("pin sdr", 32'h0, {31'h0, sdr});
      mode(11'h400);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 8'h00, {3'h0, pat_tab[i], 5'h00});
         settle();
         chk("pattern word", pat_exp[i], rx_word);
      end
      bus(1'b1, 8'h00, 11'h060);
      settle();
      chk("toggle", 32'h1, 32'(rx_word == 14'h2AAA || rx_word == 14'h1555));
      samp <= {NCH{14'h1234}};
      bus(1'b1, 8'h00, 11'h000);
      settle();
      chk("conversion", 14'h1234, rx_word);
      bus(1'b1, 8'h00, 11'h200);
      settle();
      chk("straight binary", 14'h3234, rx_word);
      summarize();
   end
endmodule : adc_output_config_registers_tb
